// *** dbc_checker.sv ***
// Per-bank command legality and state tracking for a four-bank DDR2 core
`timescale 1ns/100ps
module dbc_checker
	import dbc_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic cke,
	input wire logic [1:0] bank_addr,
	input wire logic auto_pre,
	input wire logic burst_len8,
	output logic [3:0] bank_state_0,
	output logic [3:0] bank_state_1,
	output logic [3:0] bank_state_2,
	output logic [3:0] bank_state_3,
	output logic cmd_illegal,
	output logic [2:0] cmd_code
);
	// --------------------------------------------------------------
	// Command decode
	// --------------------------------------------------------------
	function automatic dbc_cmd_t decode_cmd(input logic cs, input logic ras, input logic cas,
		input logic we);
		if (cs)
			return CMD_DSL;
		case ({ras, cas, we})
			3'h7: return CMD_NOP;
			3'h5: return CMD_READ;
			3'h4: return CMD_WRITE;
			3'h3: return CMD_ACT;
			3'h2: return CMD_PRE;
			3'h1: return CMD_REF;
			3'h0: return CMD_MRS;
			default: return CMD_NOP;
		endcase
	endfunction

	dbc_cmd_t cmd;
	assign cmd = decode_cmd(cs_n, ras_n, cas_n, we_n);

	dbc_state_t state_ff [NUM_BANKS];
	dbc_state_t nxt_state [NUM_BANKS];
	logic [7:0] timer_ff [NUM_BANKS];
	logic [7:0] nxt_timer [NUM_BANKS];
	logic [3:0] beat_ff [NUM_BANKS];
	logic [3:0] nxt_beat [NUM_BANKS];
	logic [3:0] blen_ff [NUM_BANKS];
	logic [3:0] nxt_blen [NUM_BANKS];
	logic [NUM_BANKS-1:0] bank_illegal;
	logic all_idle;
	logic is_rw;

	assign is_rw = (cmd == CMD_READ) || (cmd == CMD_WRITE);

	always_comb
	begin
		all_idle = 1'b1;
		for (int i = 0; i < NUM_BANKS; i++)
			if (state_ff[i] != ST_IDLE)
				all_idle = 1'b0;
	end

	// --------------------------------------------------------------
	// Per-bank state machines
	// --------------------------------------------------------------
	// Global commands (refresh, register set) steer every bank, so each
	// bank sees them regardless of the bank address.
	genvar g;
	generate
		for (g = 0; g < NUM_BANKS; g++)
		begin : g_bank
			logic sel;
			logic nop_like;
			logic tdone;
			logic bdone;
			assign sel = (bank_addr == 2'(g));
			assign nop_like = (cmd == CMD_DSL) || (cmd == CMD_NOP) || !sel;
			assign tdone = (timer_ff[g] <= 8'h1);
			assign bdone = (beat_ff[g] + BEAT_STEP >= blen_ff[g]);

			always_comb
			begin
				nxt_state[g] = state_ff[g];
				nxt_timer[g] = (timer_ff[g] != 8'h0) ? timer_ff[g] - 8'h1 : 8'h0;
				nxt_beat[g] = beat_ff[g];
				nxt_blen[g] = blen_ff[g];
				bank_illegal[g] = 1'b0;
				case (state_ff[g])
					ST_IDLE:
					begin
						if (cmd == CMD_REF && all_idle)
						begin
							nxt_state[g] = cke ? ST_REFRESH : ST_SELF_REF;
							nxt_timer[g] = RC_CYC;
						end
						else if (cmd == CMD_MRS && all_idle)
						begin
							nxt_state[g] = ST_MODE_ACC;
							nxt_timer[g] = MRD_CYC;
						end
						else if (sel && cmd == CMD_ACT)
						begin
							nxt_state[g] = ST_ROW_ACT;
							nxt_timer[g] = RCD_CYC;
						end
						else if (sel && is_rw)
							bank_illegal[g] = 1'b1;
					end
					ST_SELF_REF:
						if (cke)
							nxt_state[g] = ST_IDLE;
					ST_ACTIVE:
					begin
						if (cmd == CMD_REF || cmd == CMD_MRS)
							bank_illegal[g] = 1'b1;
						else if (sel && cmd == CMD_ACT)
							bank_illegal[g] = 1'b1;
						else if (sel && cmd == CMD_PRE)
						begin
							nxt_state[g] = ST_PRECH;
							nxt_timer[g] = RP_CYC;
						end
						else if (sel && is_rw)
						begin
							nxt_blen[g] = burst_len8 ? BL8_BEATS : BL4_BEATS;
							nxt_beat[g] = 4'h0;
							if (cmd == CMD_READ)
								nxt_state[g] = auto_pre ? ST_READ_AP : ST_READ;
							else
								nxt_state[g] = auto_pre ? ST_WRITE_AP : ST_WRITE;
						end
					end
					ST_READ, ST_WRITE, ST_READ_AP, ST_WRITE_AP:
					begin
						nxt_beat[g] = beat_ff[g] + BEAT_STEP;
						if (cmd == CMD_REF || cmd == CMD_MRS)
							bank_illegal[g] = 1'b1;
						else if (!nop_like)
						begin
							// Interrupt only same direction, BL8, at beat 4, no auto-precharge
							if (((state_ff[g] == ST_READ && cmd == CMD_READ)
								|| (state_ff[g] == ST_WRITE && cmd == CMD_WRITE))
								&& blen_ff[g] == BL8_BEATS && beat_ff[g] + BEAT_STEP == BL4_BEATS)
							begin
								nxt_beat[g] = 4'h0;
								nxt_blen[g] = burst_len8 ? BL8_BEATS : BL4_BEATS;
								if (auto_pre)
									nxt_state[g] = (cmd == CMD_READ) ? ST_READ_AP : ST_WRITE_AP;
							end
							else
								bank_illegal[g] = 1'b1;
						end
						else if (bdone)
						begin
							case (state_ff[g])
								ST_READ: nxt_state[g] = ST_ACTIVE;
								ST_WRITE: nxt_state[g] = ST_WREC;
								ST_READ_AP:
								begin
									nxt_state[g] = ST_PRECH;
									nxt_timer[g] = RP_CYC;
								end
								default: nxt_state[g] = ST_WREC_AP;
							endcase
							if (state_ff[g] != ST_READ_AP && state_ff[g] != ST_READ)
								nxt_timer[g] = WR_CYC;
						end
					end
					ST_PRECH:
					begin
						if (cmd == CMD_REF || cmd == CMD_MRS
							|| (sel && cmd != CMD_PRE && !nop_like))
							bank_illegal[g] = 1'b1;
						if (tdone)
							nxt_state[g] = ST_IDLE;
					end
					ST_ROW_ACT:
					begin
						if (!nop_like || cmd == CMD_REF || cmd == CMD_MRS)
							bank_illegal[g] = 1'b1;
						if (tdone)
							nxt_state[g] = ST_ACTIVE;
					end
					ST_WREC:
					begin
						if (cmd == CMD_REF || cmd == CMD_MRS || (!nop_like && cmd != CMD_WRITE))
							bank_illegal[g] = 1'b1;
						else if (sel && cmd == CMD_WRITE)
						begin
							nxt_state[g] = auto_pre ? ST_WRITE_AP : ST_WRITE;
							nxt_beat[g] = 4'h0;
							nxt_blen[g] = burst_len8 ? BL8_BEATS : BL4_BEATS;
						end
						else if (tdone)
							nxt_state[g] = ST_ACTIVE;
					end
					ST_WREC_AP:
					begin
						if (!nop_like || cmd == CMD_REF || cmd == CMD_MRS)
							bank_illegal[g] = 1'b1;
						if (tdone)
						begin
							nxt_state[g] = ST_PRECH;
							nxt_timer[g] = RP_CYC;
						end
					end
					ST_REFRESH, ST_MODE_ACC:
					begin
						// Any real command here is refused; the device only waits
						if (cmd != CMD_DSL && cmd != CMD_NOP)
							bank_illegal[g] = 1'b1;
						if (tdone)
							nxt_state[g] = ST_IDLE;
					end
					default: nxt_state[g] = ST_IDLE;
				endcase
			end

			always_ff @(posedge clock)
			begin
				if (!reset_n)
				begin
					state_ff[g] <= ST_IDLE;
					timer_ff[g] <= 8'h0;
					beat_ff[g] <= 4'h0;
					blen_ff[g] <= BL4_BEATS;
				end
				else
				begin
					state_ff[g] <= nxt_state[g];
					timer_ff[g] <= nxt_timer[g];
					beat_ff[g] <= nxt_beat[g];
					blen_ff[g] <= nxt_blen[g];
				end
			end

			wrec_ap_a: assert property (@(posedge clock) disable iff (!reset_n)
				state_ff[g] == ST_WREC_AP && timer_ff[g] == 8'h1 |=> state_ff[g] == ST_PRECH)
				else $error("write recovery with auto-precharge did not precharge");
		end
	endgenerate

	// --------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------
	logic illegal_ff;
	logic [2:0] code_ff;
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			illegal_ff <= 1'b0;
			code_ff <= 3'h0;
		end
		else
		begin
			illegal_ff <= |bank_illegal;
			code_ff <= cmd[2:0];
		end
	end
	assign cmd_illegal = illegal_ff;
	assign cmd_code = code_ff;
	assign bank_state_0 = state_ff[0];
	assign bank_state_1 = state_ff[1];
	assign bank_state_2 = state_ff[2];
	assign bank_state_3 = state_ff[3];

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	sequence prech_start_s;
		state_ff[0] != ST_PRECH ##1 state_ff[0] == ST_PRECH;
	endsequence
	sequence rowact_start_s;
		state_ff[0] != ST_ROW_ACT ##1 state_ff[0] == ST_ROW_ACT;
	endsequence

	prech_idle_a: assert property (@(posedge clock) disable iff (!reset_n)
		prech_start_s |-> ##(2) state_ff[0] == ST_IDLE)
		else $error("precharge did not end in idle after tRP");
	rowact_done_a: assert property (@(posedge clock) disable iff (!reset_n)
		rowact_start_s |-> state_ff[0] == ST_ROW_ACT ##2 state_ff[0] == ST_ACTIVE)
		else $error("row activation did not end after tRCD");
	rowact_cmd_a: assert property (@(posedge clock) disable iff (!reset_n)
		state_ff[0] == ST_ROW_ACT && bank_addr == 2'h0 && cmd == CMD_READ |=> cmd_illegal)
		else $error("read to activating bank not flagged");
	wrec_read_a: assert property (@(posedge clock) disable iff (!reset_n)
		state_ff[0] == ST_WREC && bank_addr == 2'h0 && cmd == CMD_READ |=> cmd_illegal)
		else $error("read during write recovery not flagged");
	refresh_idle_a: assert property (@(posedge clock) disable iff (!reset_n)
		state_ff[0] == ST_IDLE && all_idle && cmd == CMD_REF && cke |=> state_ff[0] == ST_REFRESH [*6] ##1 state_ff[0] == ST_IDLE)
		else $error("refresh did not last tRC");
	mode_idle_a: assert property (@(posedge clock) disable iff (!reset_n)
		all_idle && cmd == CMD_MRS |=> state_ff[0] == ST_MODE_ACC [*2] ##1 state_ff[0] == ST_IDLE)
		else $error("mode register access did not last tMRD");
	busy_refresh_a: assert property (@(posedge clock) disable iff (!reset_n)
		!all_idle && cmd == CMD_REF |=> cmd_illegal)
		else $error("refresh with busy bank not flagged");
	burst_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(state_ff[0] == ST_READ_AP) && blen_ff[0] == BL4_BEATS
		|-> ##1 state_ff[0] == ST_READ_AP ##1 state_ff[0] == ST_PRECH)
		else $error("auto-precharge burst did not run to its end");
endmodule

// *** dbc_ctrl_model.sv ***
// Controller-side command pin model for the bank checker bench
`timescale 1ns/100ps
module dbc_ctrl_model
	import dbc_pkg::*;
(
	input wire logic clock,
	input wire dbc_cmd_t cmd,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n
);
	logic [2:0] junk_ff = 3'h5;

	// ----------------------------------------
	// Command encoding
	// ----------------------------------------
	// Pins are don't-care on deselect, so they wander to prove they are ignored
	always_ff @(posedge clock)
	begin
		junk_ff <= junk_ff + 3'h1;
	end

	always_comb
	begin
		cs_n = (cmd == CMD_DSL);
		case (cmd)
			CMD_NOP: {ras_n, cas_n, we_n} = 3'h7;
			CMD_READ: {ras_n, cas_n, we_n} = 3'h5;
			CMD_WRITE: {ras_n, cas_n, we_n} = 3'h4;
			CMD_ACT: {ras_n, cas_n, we_n} = 3'h3;
			CMD_PRE: {ras_n, cas_n, we_n} = 3'h2;
			CMD_REF: {ras_n, cas_n, we_n} = 3'h1;
			CMD_MRS: {ras_n, cas_n, we_n} = 3'h0;
			default: {ras_n, cas_n, we_n} = junk_ff;
		endcase
	end
endmodule

// *** dbc_pkg.sv ***
// Package of constants and types for the DDR2 bank command state checker
package dbc_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_RP_NS = 15;
	localparam int T_RCD_NS = 15;
	localparam int T_WR_NS = 15;
	localparam int T_RC_NS = 60;
	localparam int T_MRD_CK = 2;
	localparam logic [7:0] RP_CYC = 8'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] RCD_CYC = 8'((T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] WR_CYC = 8'((T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] RC_CYC = 8'((T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] MRD_CYC = 8'(T_MRD_CK);
	localparam logic [3:0] BL4_BEATS = 4'h4;
	localparam logic [3:0] BL8_BEATS = 4'h8;
	localparam logic [3:0] BEAT_STEP = 4'h2;
	localparam int NUM_BANKS = 4;

	typedef enum logic [3:0] {
		CMD_DSL = 4'h0, CMD_NOP = 4'h1, CMD_READ = 4'h2, CMD_WRITE = 4'h3,
		CMD_ACT = 4'h4, CMD_PRE = 4'h5, CMD_REF = 4'h6, CMD_MRS = 4'h7
	} dbc_cmd_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0, ST_ACTIVE = 4'h1, ST_READ = 4'h2, ST_WRITE = 4'h3,
		ST_READ_AP = 4'h4, ST_WRITE_AP = 4'h5, ST_PRECH = 4'h6, ST_ROW_ACT = 4'h7,
		ST_WREC = 4'h8, ST_WREC_AP = 4'h9, ST_REFRESH = 4'ha, ST_MODE_ACC = 4'hb,
		ST_SELF_REF = 4'hc
	} dbc_state_t;
endpackage

// *** ddr2_bank_command_state_checker_tb.sv ***
// Self-checking bench for the DDR2 bank command state checker
`timescale 1ns/100ps
module ddr2_bank_command_state_checker_tb;
	import dbc_pkg::*;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic cke = 1'b1;
	logic [1:0] bank_addr = 2'h0;
	logic auto_pre = 1'b0;
	logic burst_len8 = 1'b0;
	dbc_cmd_t cmd = CMD_NOP;
	logic cs_n, ras_n, cas_n, we_n, cmd_illegal;
	logic [3:0] bank_state_0, bank_state_1, bank_state_2, bank_state_3;
	logic [2:0] cmd_code;
	int error_cnt = 0;
	int checks = 0;
	int seed = 91;
	int i, r;

	always #5 clock = ~clock;

	dbc_ctrl_model i_dbc_ctrl_model (.clock(clock), .cmd(cmd), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n));

	dbc_checker i_dbc_checker (.clock(clock), .reset_n(reset_n), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .cke(cke), .bank_addr(bank_addr), .auto_pre(auto_pre),
		.burst_len8(burst_len8), .bank_state_0(bank_state_0), .bank_state_1(bank_state_1),
		.bank_state_2(bank_state_2), .bank_state_3(bank_state_3), .cmd_illegal(cmd_illegal),
		.cmd_code(cmd_code));

	// ----------------------------------------
	// Checking helpers
	// ----------------------------------------
	function automatic logic [3:0] st_of(input logic [1:0] b);
		case (b)
			2'h0: st_of = bank_state_0;
			2'h1: st_of = bank_state_1;
			2'h2: st_of = bank_state_2;
			default: st_of = bank_state_3;
		endcase
	endfunction

	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task summarize;
		$display("errors=%0d checks=%0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Drive at an edge, let the next edge take it, check once outputs settle
	task automatic step(input dbc_cmd_t c, input logic [1:0] b, input logic ap,
		input logic l8, input logic [3:0] st, input logic il);
		cmd <= c;
		bank_addr <= b;
		auto_pre <= ap;
		burst_len8 <= l8;
		@(posedge clock);
		fork
		begin
			#1;
			chk(st_of(b), st);
			chk({3'h0, cmd_illegal}, {3'h0, il});
			chk({1'b0, cmd_code}, {1'b0, c[2:0]});
		end
		join_none
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		chk(bank_state_2, ST_IDLE);
		step(CMD_ACT, 0, 0, 0, ST_ROW_ACT, 0);
		step(CMD_READ, 0, 0, 0, ST_ROW_ACT, 1);
		step(CMD_ACT, 1, 0, 0, ST_ROW_ACT, 0);
		step(CMD_NOP, 0, 0, 0, ST_ACTIVE, 0);
		step(CMD_WRITE, 0, 0, 0, ST_WRITE, 0);
		step(CMD_NOP, 0, 0, 0, ST_WRITE, 0);
		step(CMD_DSL, 0, 0, 0, ST_WREC, 0);
		step(CMD_WRITE, 0, 0, 0, ST_WRITE, 0);
		step(CMD_NOP, 0, 0, 0, ST_WRITE, 0);
		step(CMD_NOP, 0, 0, 0, ST_WREC, 0);
		step(CMD_READ, 0, 0, 0, ST_WREC, 1);
		step(CMD_NOP, 0, 0, 0, ST_ACTIVE, 0);
		step(CMD_READ, 0, 0, 1, ST_READ, 0);
		step(CMD_NOP, 0, 0, 1, ST_READ, 0);
		step(CMD_READ, 0, 0, 1, ST_READ, 0);
		step(CMD_WRITE, 0, 0, 1, ST_READ, 1);
		step(CMD_NOP, 0, 0, 0, ST_READ, 0);
		step(CMD_NOP, 0, 0, 0, ST_READ, 0);
		step(CMD_NOP, 0, 0, 0, ST_ACTIVE, 0);
		step(CMD_READ, 0, 0, 0, ST_READ, 0);
		step(CMD_READ, 0, 0, 0, ST_READ, 1);
		step(CMD_NOP, 0, 0, 0, ST_ACTIVE, 0);
		step(CMD_REF, 0, 0, 0, ST_ACTIVE, 1);
		step(CMD_READ, 0, 1, 0, ST_READ_AP, 0);
		step(CMD_WRITE, 0, 0, 0, ST_READ_AP, 1);
		step(CMD_DSL, 0, 0, 0, ST_PRECH, 0);
		step(CMD_PRE, 0, 0, 0, ST_PRECH, 0);
		step(CMD_NOP, 0, 0, 0, ST_IDLE, 0);
		step(CMD_WRITE, 1, 1, 0, ST_WRITE_AP, 0);
		step(CMD_NOP, 1, 0, 0, ST_WRITE_AP, 0);
		step(CMD_NOP, 1, 0, 0, ST_WREC_AP, 0);
		step(CMD_WRITE, 1, 0, 0, ST_WREC_AP, 1);
		step(CMD_NOP, 1, 0, 0, ST_PRECH, 0);
		step(CMD_NOP, 1, 0, 0, ST_PRECH, 0);
		step(CMD_NOP, 1, 0, 0, ST_IDLE, 0);
		step(CMD_REF, 0, 0, 0, ST_REFRESH, 0);
		step(CMD_ACT, 0, 0, 0, ST_REFRESH, 1);
		repeat (4) step(CMD_NOP, 0, 0, 0, ST_REFRESH, 0);
		step(CMD_NOP, 0, 0, 0, ST_IDLE, 0);
		step(CMD_MRS, 0, 0, 0, ST_MODE_ACC, 0);
		step(CMD_NOP, 0, 0, 0, ST_MODE_ACC, 0);
		step(CMD_NOP, 0, 0, 0, ST_IDLE, 0);
		step(CMD_PRE, 3, 0, 0, ST_IDLE, 0);
		cke <= 1'b0;
		step(CMD_REF, 0, 0, 0, ST_SELF_REF, 0);
		cke <= 1'b1;
		cmd <= CMD_NOP;
		// Look after the entry edge has settled, or the old idle state ends the wait at once
		#1;
		// Exit latency is the design's choice, so only bound it
		for (i = 0; i < 20 && bank_state_0 !== ST_IDLE; i++)
		begin
			@(posedge clock);
			#1;
		end
		chk(bank_state_0, ST_IDLE);
		if (i == 20)
			summarize();
		@(posedge clock);
		for (i = 0; i < 40; i++)
		begin
			r = $random(seed);
			step(r[0] ? CMD_NOP : CMD_DSL, r[2:1], r[3], r[4], ST_IDLE, 0);
		end
		r = $random(seed);
		step(CMD_ACT, r[1:0], 0, 0, ST_ROW_ACT, 0);
		step(CMD_NOP, r[1:0], 0, 0, ST_ROW_ACT, 0);
		step(CMD_NOP, r[1:0], 0, 0, ST_ACTIVE, 0);
		repeat (2) @(posedge clock);
		summarize();
	end
endmodule
